// >>> core/crm_defines.svh
// Constants for the processor register set: reset values, vectors, direct page, CCR ones.
// Assumes inclusion by bare name from core/ sources.
`ifndef CRM_DEFINES_SVH
`define CRM_DEFINES_SVH
`define CRM_IDX_HI_RST 8'h00
`define CRM_SP_RST 16'h00FF
`define CRM_PC_RST 16'h0000
`define CRM_VEC_HI_ADDR 16'hFFFE
`define CRM_VEC_LO_ADDR 16'hFFFF
`define CRM_DIRECT_PAGE 8'h00
`define CRM_CCR_ONES 8'h60
`define CRM_STACK_LOW_RST 8'hFF
`endif

// >>> core/crm_pkg.sv
// Types for the processor register set.
// Assumes crm_defines.svh supplies constants.
package crm_pkg;
  // Sequencer commands to the register set
  typedef enum logic [3:0] {
    CRM_OP_NONE = 4'h0, CRM_OP_LD_A = 4'h1, CRM_OP_LD_X = 4'h2, CRM_OP_LD_H = 4'h3,
    CRM_OP_LD_HX = 4'h4, CRM_OP_X_CLR = 4'h5, CRM_OP_X_INC = 4'h6, CRM_OP_X_DEC = 4'h7,
    CRM_OP_X_COM = 4'h8, CRM_OP_X_NEG = 4'h9, CRM_OP_X_SHL = 4'hA, CRM_OP_X_SHR = 4'hB,
    CRM_OP_X_ROL = 4'hC, CRM_OP_X_ROR = 4'hD, CRM_OP_LD_CCR = 4'hE
  } crm_op_e;
  // Stack pointer commands
  typedef enum logic [2:0] {
    CRM_SP_NONE = 3'h0, CRM_SP_PUSH = 3'h1, CRM_SP_PULL = 3'h2,
    CRM_SP_ADJUST = 3'h3, CRM_SP_LOW_RST = 3'h4, CRM_SP_LOAD = 3'h5
  } crm_sp_e;
  // Reset vector fetch states, one-hot
  typedef enum logic [3:0] {
    CRM_ST_HI = 4'b0001, CRM_ST_LO = 4'b0010, CRM_ST_RUN = 4'b0100, CRM_ST_WAIT = 4'b1000
  } crm_st_e;
endpackage

// >>> core/crm_pc_if.sv
// Interface carrying program counter controls between the core and its counter.
// Assumes one clock domain shared with the register set.
`timescale 1ns/1ns
`default_nettype none
interface crm_pc_if;
  logic inc;        // Sequential advance
  logic load;       // Change-of-flow load
  logic [15:0] tgt; // Load target
  logic [15:0] pc;  // Current value
  modport core (output inc, output load, output tgt, input pc);
  modport cnt (input inc, input load, input tgt, output pc);
endinterface
`default_nettype wire

// >>> core/crm_pc_counter.sv
// Program counter: advances per fetched byte or loads a new target.
// Assumes the core drives at most one of inc or load meaningfully; load wins.
`timescale 1ns/1ns
`default_nettype none
`include "crm_defines.svh"
module crm_pc_counter
  import crm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control
  crm_pc_if.cnt pcb
);
  logic [15:0] pc_q;  // Counter value
  logic [15:0] next_pc;
  // Next value: load beats increment
  always_comb
  begin
    next_pc = pc_q;
    if (pcb.load)
    begin
      next_pc = pcb.tgt; // [RQ11]
    end
    else if (pcb.inc)
    begin
      next_pc = pc_q + 16'h0001; // [RQ10]
    end
  end
  // Register
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      pc_q <= `CRM_PC_RST; // Cleared until the vector fetch loads it
    else if (ce_i)
      pc_q <= next_pc;
  end
  assign pcb.pc = pc_q;
endmodule
`default_nettype wire

// >>> core/crm_regs.sv
// Programmer-visible register set of an 8-bit core: A, H:X, SP, PC, CCR.
// Assumes a sequencer drives commands on mclk_i and memory answers reads in one cycle.
// Overview of operation
// RQ1 - Accumulator untouched by reset
// RQ2 - Reset clears H, keeps X
// RQ3 - H is high byte, X low byte
// RQ4 - Indexed address uses full H:X
// RQ5 - X usable as general 8-bit register
// RQ6 - Reset loads SP with 0x00FF
// RQ7 - SP addresses next free stack byte
// RQ8 - Stack adjust adds sign-extended immediate
// RQ9 - Stack low reset changes only low byte
// RQ10 - PC increments per fetched byte
// RQ11 - Change-of-flow loads PC target
// RQ12 - Reset loads PC from top vector
// RQ13 - Registers not memory mapped
// RQ14 - Direct address from one byte
// RQ15 - CCR bits 6 and 5 read one
// RQ16 - Updates visible to next instruction
`timescale 1ns/1ns
`default_nettype none
`include "crm_defines.svh"
module crm_regs
  import crm_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Data register commands
  input wire logic [3:0] op_i,
  input wire logic [7:0] data_i,
  input wire logic [15:0] word_i,
  // Stack pointer commands
  input wire logic [2:0] sp_op_i,
  input wire logic [7:0] imm_i,
  input wire logic [15:0] sp_word_i,
  // Program counter commands
  input wire logic pc_inc_i,
  input wire logic pc_load_i,
  input wire logic [15:0] pc_tgt_i,
  // Memory read port for the reset vector fetch
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  input wire logic [7:0] mem_rdata_i,
  // Address formation inputs
  input wire logic [7:0] dir_byte_i,
  // Register views
  output logic [7:0] acc_o,
  output logic [7:0] idx_hi_o,
  output logic [7:0] idx_lo_o,
  output logic [15:0] idx_o,
  output logic [15:0] sp_o,
  output logic [15:0] pc_o,
  output logic [7:0] ccr_o,
  output logic [15:0] dir_addr_o,
  output logic running_o
);
  crm_pc_if pcb ();  // Counter link
  logic [7:0] acc;   // Accumulator, no reset
  logic [7:0] idx_hi; // Index upper byte
  logic [7:0] idx_lo; // Index lower byte, no reset
  logic [15:0] sp;   // Stack pointer
  logic [7:0] ccr;   // Condition codes
  logic [7:0] vec_hi; // Captured vector high byte
  crm_st_e st;       // Vector fetch state
  logic [7:0] next_acc;
  logic [7:0] next_idx_hi;
  logic [7:0] next_idx_lo;
  logic [15:0] next_sp;
  logic [7:0] next_ccr;
  logic [7:0] next_vec_hi;
  crm_st_e next_st;
  logic run;         // Out of vector fetch

  assign run = (st == CRM_ST_RUN);

  // Data registers: A, H, X, CCR next values
  always_comb
  begin
    next_acc = acc;
    next_idx_hi = idx_hi;
    next_idx_lo = idx_lo;
    next_ccr = ccr;
    if (run)
    begin
      case (crm_op_e'(op_i))
        CRM_OP_LD_A: next_acc = data_i;
        CRM_OP_LD_X: next_idx_lo = data_i;
        CRM_OP_LD_H: next_idx_hi = data_i;
        CRM_OP_LD_HX:
        begin
          next_idx_hi = word_i[15:8]; // [RQ3]
          next_idx_lo = word_i[7:0];
        end
        CRM_OP_X_CLR: next_idx_lo = 8'h00; // [RQ5]
        CRM_OP_X_INC: next_idx_lo = idx_lo + 8'h01; // [RQ5]
        CRM_OP_X_DEC: next_idx_lo = idx_lo - 8'h01; // [RQ5]
        CRM_OP_X_COM: next_idx_lo = ~idx_lo; // [RQ5]
        CRM_OP_X_NEG: next_idx_lo = 8'h00 - idx_lo; // [RQ5]
        CRM_OP_X_SHL: next_idx_lo = {idx_lo[6:0], 1'b0}; // [RQ5]
        CRM_OP_X_SHR: next_idx_lo = {1'b0, idx_lo[7:1]}; // [RQ5]
        CRM_OP_X_ROL: next_idx_lo = {idx_lo[6:0], ccr[0]}; // [RQ5]
        CRM_OP_X_ROR: next_idx_lo = {ccr[0], idx_lo[7:1]}; // [RQ5]
        CRM_OP_LD_CCR: next_ccr = data_i | `CRM_CCR_ONES; // [RQ15]
        default: next_ccr = ccr;
      endcase
    end
  end

  // A and X hold across reset; no reset branch at all
  always_ff @(posedge mclk_i)
  begin
    if (ce_i)
    begin
      acc <= next_acc; // [RQ1]
      idx_lo <= next_idx_lo; // [RQ2]
    end
  end

  // H and CCR reset
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      idx_hi <= `CRM_IDX_HI_RST; // [RQ2]
      ccr <= `CRM_CCR_ONES;
    end
    else if (ce_i)
    begin
      idx_hi <= next_idx_hi;
      ccr <= next_ccr;
    end
  end

  // Stack pointer next value
  always_comb
  begin
    next_sp = sp;
    if (run)
    begin
      case (crm_sp_e'(sp_op_i))
        CRM_SP_PUSH: next_sp = sp - 16'h0001; // [RQ7]
        CRM_SP_PULL: next_sp = sp + 16'h0001; // [RQ7]
        CRM_SP_ADJUST: next_sp = sp + {{8{imm_i[7]}}, imm_i}; // [RQ8]
        CRM_SP_LOW_RST: next_sp = {sp[15:8], `CRM_STACK_LOW_RST}; // [RQ9]
        CRM_SP_LOAD: next_sp = sp_word_i;
        default: next_sp = sp;
      endcase
    end
  end

  // Stack pointer register
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      sp <= `CRM_SP_RST; // [RQ6]
    else if (ce_i)
      sp <= next_sp;
  end

  // Vector fetch sequence: high byte, then low byte, then run
  always_comb
  begin
    next_st = st;
    next_vec_hi = vec_hi;
    case (st)
      CRM_ST_HI: next_st = CRM_ST_WAIT;
      CRM_ST_WAIT:
      begin
        next_vec_hi = mem_rdata_i; // [RQ12]
        next_st = CRM_ST_LO;
      end
      CRM_ST_LO: next_st = CRM_ST_RUN;
      CRM_ST_RUN: next_st = CRM_ST_RUN;
      default: next_st = CRM_ST_HI;
    endcase
  end

  // Sequence registers
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= CRM_ST_HI;
      vec_hi <= 8'h00;
    end
    else if (ce_i)
    begin
      st <= next_st;
      vec_hi <= next_vec_hi;
    end
  end

  // Memory read request during vector fetch
  always_comb
  begin
    mem_rd_o = 1'b0;
    mem_addr_o = `CRM_VEC_HI_ADDR;
    if (st == CRM_ST_HI)
    begin
      mem_rd_o = 1'b1;
      mem_addr_o = `CRM_VEC_HI_ADDR; // [RQ12]
    end
    else if (st == CRM_ST_WAIT)
    begin
      mem_rd_o = 1'b1;
      mem_addr_o = `CRM_VEC_LO_ADDR; // [RQ12]
    end
  end

  // Counter control: vector load at end of fetch, else sequencer
  always_comb
  begin
    pcb.inc = run & pc_inc_i; // [RQ10]
    pcb.load = 1'b0;
    pcb.tgt = pc_tgt_i;
    if (st == CRM_ST_LO)
    begin
      pcb.load = 1'b1;
      pcb.tgt = {vec_hi, mem_rdata_i}; // [RQ12]
    end
    else if (run & pc_load_i)
    begin
      pcb.load = 1'b1; // [RQ11]
    end
  end

  crm_pc_counter u_pc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pcb(pcb)
  );

  // Views are the registers themselves, visible the cycle after update; dir_addr_o follows dir_byte_i in the same cycle
  assign acc_o = acc; // [RQ16]
  assign idx_hi_o = idx_hi;
  assign idx_lo_o = idx_lo;
  assign idx_o = {idx_hi, idx_lo}; // [RQ4]
  assign sp_o = sp;
  assign pc_o = pcb.pc;
  assign ccr_o = ccr | `CRM_CCR_ONES; // [RQ15]
  assign dir_addr_o = {`CRM_DIRECT_PAGE, dir_byte_i}; // [RQ14]
  assign running_o = run; // [RQ13]
endmodule
`default_nettype wire

// >>> sim/crm_regs_asserts.sv
// Port checker for the register set.
// Assumes a bind onto crm_regs, one clock.
`timescale 1ns/1ns
`default_nettype none
module crm_regs_asserts
  import crm_pkg::*;
(
  // Clock and commands
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] op_i,
  input wire logic [7:0] data_i,
  input wire logic [2:0] sp_op_i,
  input wire logic [7:0] imm_i,
  input wire logic pc_inc_i,
  input wire logic pc_load_i,
  input wire logic [15:0] pc_tgt_i,
  input wire logic [7:0] dir_byte_i,
  // Register views
  input wire logic mem_rd_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0] acc_o,
  input wire logic [7:0] idx_hi_o,
  input wire logic [7:0] idx_lo_o,
  input wire logic [15:0] idx_o,
  input wire logic [15:0] sp_o,
  input wire logic [15:0] pc_o,
  input wire logic [7:0] ccr_o,
  input wire logic [15:0] dir_addr_o,
  input wire logic running_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Command is taken at this edge
  wire logic go = ce_i && running_o;
  chk_dir_page: assert property (dir_addr_o == {8'h00, dir_byte_i})
    else $error("direct address wrong");
  chk_idx_join: assert property (idx_o == {idx_hi_o, idx_lo_o})
    else $error("index pair wrong");
  chk_ccr_ones: assert property (ccr_o[6:5] == 2'b11)
    else $error("ccr fixed bits wrong");
  chk_acc_load: assert property (go && op_i == CRM_OP_LD_A |=> acc_o == $past(data_i))
    else $error("acc load late");
  chk_x_inc: assert property (go && op_i == CRM_OP_X_INC |=> idx_lo_o == $past(idx_lo_o) + 8'h01)
    else $error("x inc wrong");
  chk_sp_adjust: assert property (go && sp_op_i == CRM_SP_ADJUST |=> sp_o == $past(sp_o) + 16'($signed($past(imm_i))))
    else $error("sp adjust wrong");
  chk_sp_low: assert property (go && sp_op_i == CRM_SP_LOW_RST |=> sp_o[7:0] == 8'hFF && $stable(sp_o[15:8]))
    else $error("sp low reset wrong");
  chk_pc_step: assert property (go && pc_inc_i && !pc_load_i |=> pc_o == $past(pc_o) + 16'h0001)
    else $error("pc step wrong");
  chk_pc_load: assert property (go && pc_load_i |=> pc_o == $past(pc_tgt_i))
    else $error("pc load wrong");
  chk_vec_order: assert property ($fell(rst_i) |-> mem_rd_o && mem_addr_o == 16'hFFFE ##1 mem_rd_o && mem_addr_o == 16'hFFFF)
    else $error("vector order wrong");
  chk_reset_vals: assert property ($fell(rst_i) |-> sp_o == 16'h00FF && idx_hi_o == 8'h00)
    else $error("reset values wrong");
endmodule
bind crm_regs crm_regs_asserts u_chk (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .op_i(op_i),
  .data_i(data_i),
  .sp_op_i(sp_op_i),
  .imm_i(imm_i),
  .pc_inc_i(pc_inc_i),
  .pc_load_i(pc_load_i),
  .pc_tgt_i(pc_tgt_i),
  .dir_byte_i(dir_byte_i),
  .mem_rd_o(mem_rd_o),
  .mem_addr_o(mem_addr_o),
  .acc_o(acc_o),
  .idx_hi_o(idx_hi_o),
  .idx_lo_o(idx_lo_o),
  .idx_o(idx_o),
  .sp_o(sp_o),
  .pc_o(pc_o),
  .ccr_o(ccr_o),
  .dir_addr_o(dir_addr_o),
  .running_o(running_o)
);
`default_nettype wire

// >>> sim/crm_regs_tb.sv
// Self-checking bench for the register set.
// Assumes crm_regs and its checker compiled first.
`timescale 1ns/1ns
`default_nettype none
module crm_regs_tb
  import crm_pkg::*;
;
  logic mclk_i = 0, rst_i = 1, ce_i = 1, pc_inc_i = 0, pc_load_i = 0, mem_rd_o, running_o;
  logic [3:0] op_i = 0;
  logic [2:0] sp_op_i = 0;
  logic [7:0] data_i = 0, imm_i = 0, mem_rdata_i = 0, dir_byte_i = 0, acc_o, idx_hi_o, idx_lo_o, ccr_o;
  logic [15:0] word_i = 0, sp_word_i = 0, pc_tgt_i = 0, mem_addr_o, idx_o, sp_o, pc_o, dir_addr_o;
  logic [15:0] last_a = 0;
  logic [7:0] ex [9] = '{8'h00, 8'h17, 8'h15, 8'hE9, 8'hEA, 8'h2C, 8'h0B, 8'h2D, 8'h8B};
  int errors = 0, cmp_count = 0;
  crm_regs i_dut (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .op_i(op_i),
    .data_i(data_i),
    .word_i(word_i),
    .sp_op_i(sp_op_i),
    .imm_i(imm_i),
    .sp_word_i(sp_word_i),
    .pc_inc_i(pc_inc_i),
    .pc_load_i(pc_load_i),
    .pc_tgt_i(pc_tgt_i),
    .mem_rd_o(mem_rd_o),
    .mem_addr_o(mem_addr_o),
    .mem_rdata_i(mem_rdata_i),
    .dir_byte_i(dir_byte_i),
    .acc_o(acc_o),
    .idx_hi_o(idx_hi_o),
    .idx_lo_o(idx_lo_o),
    .idx_o(idx_o),
    .sp_o(sp_o),
    .pc_o(pc_o),
    .ccr_o(ccr_o),
    .dir_addr_o(dir_addr_o),
    .running_o(running_o)
  );
  initial forever #5 mclk_i = ~mclk_i;
  // Vector memory answers a cycle after the address
  always @(posedge mclk_i) last_a <= mem_rd_o ? mem_addr_o : 16'h0000;
  always @(negedge mclk_i) mem_rdata_i <= last_a == 16'hFFFE ? 8'hA5 : last_a == 16'hFFFF ? 8'h3C : ~mem_rdata_i;
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task give_verdict;
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic dop(input crm_op_e o, input logic [7:0] d);
    op_i = o;
    data_i = d;
    @(negedge mclk_i);
  endtask
  task automatic sop(input crm_sp_e o, input logic [7:0] i, input logic [15:0] w);
    sp_op_i = o;
    imm_i = i;
    sp_word_i = w;
    @(negedge mclk_i);
  endtask
  // Reset, then wait for the vector fetch to finish
  task do_reset;
    rst_i = 1;
    repeat (5) @(negedge mclk_i);
    rst_i = 0;
    repeat (4) @(negedge mclk_i);
    chk("run", running_o, 1);
    chk("pc", pc_o, 16'hA53C);
    chk("sp", sp_o, 16'h00FF);
    chk("h", idx_hi_o, 0);
  endtask
  // Back-to-back steps, load wins, enable low holds
  task scn_pc;
    pc_inc_i = 1;
    repeat (3) @(negedge mclk_i);
    chk("pc", pc_o, 16'hA53F);
    pc_load_i = 1;
    pc_tgt_i = 16'h4000;
    @(negedge mclk_i);
    chk("pc", pc_o, 16'h4000);
    pc_load_i = 0;
    ce_i = 0;
    repeat (2) @(negedge mclk_i);
    chk("pc", pc_o, 16'h4000);
    ce_i = 1;
    pc_inc_i = 0;
  endtask
  // Every X operation on a fresh value; rotates see carry set
  task scn_x;
    for (int i = 0; i < 9; i++)
    begin
      dop(CRM_OP_LD_CCR, (i >= 7) ? 8'h01 : 8'h00);
      dop(CRM_OP_LD_X, 8'h16);
      dop(crm_op_e'(i + 5), 8'h00);
      chk("x", idx_lo_o, ex[i]);
    end
    chk("ccr", ccr_o, 8'h61);
    word_i = 16'hBEEF;
    dop(CRM_OP_LD_HX, 8'h00);
    chk("hx", idx_o, 16'hBEEF);
    dop(CRM_OP_NONE, 8'h00);
  endtask
  // Signed adjust both ways, low reset, push
  task scn_sp;
    sop(CRM_SP_LOAD, 0, 16'h1280);
    sop(CRM_SP_ADJUST, 8'h80, 0);
    chk("sp", sp_o, 16'h1200);
    sop(CRM_SP_ADJUST, 8'h7F, 0);
    chk("sp", sp_o, 16'h127F);
    sop(CRM_SP_LOW_RST, 0, 0);
    chk("sp", sp_o, 16'h12FF);
    sop(CRM_SP_PUSH, 0, 0);
    chk("sp", sp_o, 16'h12FE);
    sop(CRM_SP_PULL, 0, 0);
    chk("sp", sp_o, 16'h12FF);
    sop(CRM_SP_NONE, 0, 0);
  endtask
  // Reset in mid-run keeps A and X
  task scn_keep;
    dop(CRM_OP_LD_A, 8'h5A);
    chk("a", acc_o, 8'h5A);
    dop(CRM_OP_LD_X, 8'hC3);
    dop(CRM_OP_LD_H, 8'h77);
    dop(CRM_OP_NONE, 8'h00);
    do_reset;
    chk("a", acc_o, 8'h5A);
    chk("hx", idx_o, 16'h00C3);
    for (int i = 0; i < 256; i += 255)
    begin
      dir_byte_i = 8'(i);
      @(negedge mclk_i);
      chk("dir", dir_addr_o, 16'(i));
    end
  endtask
  initial
  begin
    #20000;
    errors++;
    give_verdict;
  end
  initial
  begin
    do_reset;
    scn_pc;
    scn_x;
    scn_sp;
    scn_keep;
    give_verdict;
  end
endmodule
`default_nettype wire
